// ===== logic/epb_cfg.svh
`ifndef EPB_CFG_SVH
`define EPB_CFG_SVH
// Address and data widths
`define EPB_AW 32
`define EPB_DW 64
// Bank decode field position and codes
`define EPB_BANK_HI 31
`define EPB_BANK_LO 27
`define EPB_BANK0_CODE 5'h06
`define EPB_BANK1_CODE 5'h07
// Host space decode bit
`define EPB_HOST_BIT 31
// Address bits of internal slave memory (16 words)
`define EPB_MEM_AW 4
// Edges after issue before the synced wait release belongs to the access
`define EPB_ACK_LAT 2'h2
`endif

// ===== logic/epb_pkg.sv
`default_nettype none
`include "epb_cfg.svh"
package epb_pkg;
	// Master request from the core
	typedef struct packed {
		logic                  rd;    // Read request
		logic                  wr;    // Write request
		logic                  long_word; // 64-bit write
		logic                  bus32; // Zone is 32 bits wide
		logic                  sdram; // Target is SDRAM
		logic                  boot;  // Target is boot memory
		logic                  burst; // Consecutive address access
		logic [`EPB_AW-1:0]    addr;  // Address
		logic [`EPB_DW-1:0]    wdata; // Write data
	} epb_req_t;
	// Master states
	typedef enum logic [1:0] {
		EPB_IDLE,
		EPB_ACCESS
	} epb_state_t;
endpackage : epb_pkg
`default_nettype wire

// ===== logic/epb_mem.sv
`default_nettype none
`include "epb_cfg.svh"
module epb_mem (
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_we_low,
	input  wire logic                    i_we_high,
	input  wire logic [`EPB_MEM_AW-1:0]  i_addr,
	input  wire logic [`EPB_DW-1:0]      i_wdata,
	output logic      [`EPB_DW-1:0]      o_rdata
);
	// Storage array
	logic [`EPB_DW-1:0] mem [0:(1<<`EPB_MEM_AW)-1];
	// Split word writes, registered read
	always_ff @(posedge i_sys_clk) begin
		if (i_we_low) begin
			mem[i_addr][31:0] <= i_wdata[31:0];
		end
		if (i_we_high) begin
			mem[i_addr][63:32] <= i_wdata[63:32];
		end
		o_rdata <= mem[i_addr];
	end
endmodule : epb_mem
`default_nettype wire

// ===== logic/epb_ctrl.sv
// Functional notes
// - Drive address as master, take it as slave
// - Drive and receive the 64-bit data bus
// - Read strobe on every non-SDRAM read
// - Slave read strobe is an input
// - Low strobe: even word or 32-bit zone
// - High strobe: long word or odd word
// - Slave write strobes are inputs
// - Strobes and selects change with address
// - Only the bus master drives controls
// - Master extends access while wait released low
// - Slave may insert wait states
// - Boot select is boot memory chip select
// - Boot select sampled as strap at reset
// - Bank selects decode address bits 31:27
// - Host select decodes top address bit
// - Master marks consecutive accesses with burst
// - Slave increments address during host burst
`default_nettype none
`include "epb_cfg.svh"
module epb_ctrl (
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_resetn,
	// Core side
	input  wire logic                 i_is_master,   // Bus ownership
	input  wire epb_pkg::epb_req_t    i_req,         // Master request
	output logic                      o_req_done,    // Access completed
	output logic      [`EPB_DW-1:0]   o_rd_data,     // Master read data
	output logic                      o_eprom_boot_strap, // Strap caught at reset
	output logic                      o_slave_wait,  // Slave inserts wait
	// Address bus
	input  wire logic [`EPB_AW-1:0]   i_addr,
	output logic      [`EPB_AW-1:0]   o_addr,
	output logic                      o_addr_oe,
	// Data bus
	input  wire logic [`EPB_DW-1:0]   i_data,
	output logic      [`EPB_DW-1:0]   o_data,
	output logic                      o_data_oe,
	// Strobes, active low
	input  wire logic                 i_read_strobe_n,
	input  wire logic                 i_write_low_strobe_n,
	input  wire logic                 i_write_high_strobe_n,
	output logic                      o_read_strobe_n,
	output logic                      o_write_low_strobe_n,
	output logic                      o_write_high_strobe_n,
	output logic                      o_strobe_oe,
	// Wait release, open drain
	input  wire logic                 i_wait_release,
	output logic                      o_wait_release,
	output logic                      o_wait_release_oe,
	// Selects, active low
	input  wire logic                 i_boot_memory_select_n,
	output logic                      o_boot_memory_select_n,
	output logic                      o_bank_select_0_n,
	output logic                      o_bank_select_1_n,
	output logic                      o_host_space_select_n,
	output logic                      o_select_oe,
	// Burst
	input  wire logic                 i_burst_indicator_n,
	output logic                      o_burst_indicator_n,
	output logic                      o_burst_oe
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	localparam int SW = `EPB_AW + `EPB_DW + 6;
	logic [SW-1:0] sync1;  // First stage
	logic [SW-1:0] sync2;  // Second stage
	logic [SW-1:0] pin_in; // Raw pin bundle
	assign pin_in = {i_addr, i_data, i_read_strobe_n, i_write_low_strobe_n,
		i_write_high_strobe_n, i_wait_release, i_boot_memory_select_n, i_burst_indicator_n};
	// Two-flop chain, free running so the boot pin is seen through reset
	always_ff @(posedge i_sys_clk) begin
		sync1 <= pin_in;
		sync2 <= sync1;
	end
	logic [`EPB_AW-1:0] s_addr;   // Synced address
	logic [`EPB_DW-1:0] s_data;   // Synced data
	logic s_rd, s_wl, s_wh, s_ack, s_bms, s_burst_indicator; // Synced strobes, active high
	assign s_addr = sync2[SW-1 -: `EPB_AW];
	assign s_data = sync2[6 +: `EPB_DW];
	assign s_rd   = !sync2[5];
	assign s_wl   = !sync2[4];
	assign s_wh   = !sync2[3];
	assign s_ack  = sync2[2];
	assign s_bms  = !sync2[1];
	assign s_burst_indicator = !sync2[0];

	// ****************************************
	// Boot strap capture
	// ****************************************
	logic strap_done;      // Strap taken once
	logic next_strap_done; // Next strap state
	logic strap;           // Strap value
	logic next_strap;      // Next strap value
	// Catch the boot pin on the first edge after release
	always_comb begin
		next_strap_done = 1'b1;
		next_strap = strap_done ? strap : s_bms;
	end
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			strap_done <= 1'b0;
			strap <= 1'b0;
		end else begin
			strap_done <= next_strap_done;
			strap <= next_strap;
		end
	end
	assign o_eprom_boot_strap = strap;

	// ****************************************
	// Master access sequencer
	// ****************************************
	epb_pkg::epb_state_t state, next_state;
	logic [`EPB_AW-1:0] m_addr, next_m_addr;     // Driven address
	logic [`EPB_DW-1:0] m_data, next_m_data;     // Driven write data
	logic m_rd, next_m_rd;       // Read strobe active
	logic m_wl, next_m_wl;       // Low strobe active
	logic m_wh, next_m_wh;       // High strobe active
	logic m_bms, next_m_bms;     // Boot select active
	logic m_b0, next_m_b0;       // Bank 0 select
	logic m_b1, next_m_b1;       // Bank 1 select
	logic m_hs, next_m_hs;       // Host select
	logic m_burst_indicator, next_m_burst_indicator;   // Burst active
	logic m_wdrv, next_m_wdrv;   // Data driven
	logic done, next_done;       // Completion pulse
	logic [`EPB_DW-1:0] rdat, next_rdat; // Captured read data
	logic [1:0] acc_age, next_acc_age;   // Edges since issue, saturating
	// Issue, hold while wait released low, then finish
	always_comb begin
		next_state = state;
		next_m_addr = m_addr;
		next_m_data = m_data;
		next_m_rd = m_rd;
		next_m_wl = m_wl;
		next_m_wh = m_wh;
		next_m_bms = m_bms;
		next_m_b0 = m_b0;
		next_m_b1 = m_b1;
		next_m_hs = m_hs;
		next_m_burst_indicator = m_burst_indicator;
		next_m_wdrv = m_wdrv;
		next_done = 1'b0;
		next_rdat = rdat;
		next_acc_age = acc_age;
		case (state)
			epb_pkg::EPB_IDLE: begin
				next_m_burst_indicator = 1'b0;
				if (i_is_master && (i_req.rd || i_req.wr)) begin
					next_state = epb_pkg::EPB_ACCESS;
					// All controls load with the address in one cycle
					next_m_addr = i_req.addr;
					next_m_data = i_req.wdata;
					next_m_rd = i_req.rd && !i_req.sdram;
					next_m_wl = i_req.wr && (i_req.bus32 || !i_req.addr[0] || i_req.long_word);
					next_m_wh = i_req.wr && !i_req.bus32 && (i_req.long_word || i_req.addr[0]);
					next_m_bms = i_req.boot;
					next_m_b0 = i_req.addr[`EPB_BANK_HI:`EPB_BANK_LO] == `EPB_BANK0_CODE;
					next_m_b1 = i_req.addr[`EPB_BANK_HI:`EPB_BANK_LO] == `EPB_BANK1_CODE;
					next_m_hs = i_req.addr[`EPB_HOST_BIT];
					next_m_burst_indicator = i_req.burst;
					next_m_wdrv = i_req.wr;
					next_acc_age = 2'h0;
				end
			end
			epb_pkg::EPB_ACCESS: begin
				// Synced wait release lags the pins, so early samples are stale
				next_acc_age = acc_age + {1'b0, acc_age != `EPB_ACK_LAT};
				if ((s_ack && acc_age == `EPB_ACK_LAT) || !i_is_master) begin
					next_state = epb_pkg::EPB_IDLE;
					next_done = i_is_master;
					next_rdat = s_data;
					next_m_rd = 1'b0;
					next_m_wl = 1'b0;
					next_m_wh = 1'b0;
					next_m_bms = 1'b0;
					next_m_b0 = 1'b0;
					next_m_b1 = 1'b0;
					next_m_hs = 1'b0;
					next_m_wdrv = 1'b0;
				end
			end
			default: next_state = epb_pkg::EPB_IDLE;
		endcase
	end
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= epb_pkg::EPB_IDLE;
			m_addr <= '0;
			m_data <= '0;
			{m_rd, m_wl, m_wh, m_bms, m_b0, m_b1, m_hs, m_burst_indicator, m_wdrv, done} <= '0;
			rdat <= '0;
			acc_age <= 2'h0;
		end else begin
			state <= next_state;
			m_addr <= next_m_addr;
			m_data <= next_m_data;
			{m_rd, m_wl, m_wh, m_bms, m_b0, m_b1, m_hs, m_burst_indicator, m_wdrv, done} <=
				{next_m_rd, next_m_wl, next_m_wh, next_m_bms, next_m_b0, next_m_b1,
				next_m_hs, next_m_burst_indicator, next_m_wdrv, next_done};
			rdat <= next_rdat;
			acc_age <= next_acc_age;
		end
	end
	assign o_req_done = done;
	assign o_rd_data = rdat;

	// ****************************************
	// Output enables and pin drive
	// ****************************************
	logic own, next_own; // Registered ownership
	always_comb begin
		next_own = i_is_master;
	end
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			own <= 1'b0;
		end else begin
			own <= next_own;
		end
	end
	assign o_addr_oe = own;
	assign o_strobe_oe = own;
	assign o_select_oe = own;
	assign o_burst_oe = own;
	assign o_addr = m_addr;
	assign o_read_strobe_n = !m_rd;
	assign o_write_low_strobe_n = !m_wl;
	assign o_write_high_strobe_n = !m_wh;
	assign o_boot_memory_select_n = !m_bms;
	assign o_bank_select_0_n = !m_b0;
	assign o_bank_select_1_n = !m_b1;
	assign o_host_space_select_n = !m_hs;
	assign o_burst_indicator_n = !m_burst_indicator;

	// ****************************************
	// Slave access to internal memory
	// ****************************************
	logic [`EPB_MEM_AW-1:0] s_ptr, next_s_ptr; // Target word pointer
	logic in_burst, next_in_burst;             // Burst already started
	logic s_wait, next_s_wait;                 // One wait state on reads
	logic slv_drive, next_slv_drive;           // Drive read data
	logic [`EPB_DW-1:0] slv_rdata;             // Memory read data
	logic slv_act;                             // Slave strobe seen
	assign slv_act = !own && (s_rd || s_wl || s_wh);
	logic [`EPB_MEM_AW-1:0] slv_addr;          // Word this transfer targets
	logic slv_done;                            // Transfer completes this cycle
	assign slv_addr = (in_burst && s_burst_indicator) ? s_ptr : s_addr[`EPB_MEM_AW-1:0];
	assign slv_done = slv_act && !(s_rd && !s_wait);
	// Pointer: first address, then count during burst
	always_comb begin
		next_s_ptr = s_ptr;
		next_in_burst = in_burst && s_burst_indicator;
		next_s_wait = 1'b0;
		next_slv_drive = 1'b0;
		if (slv_act) begin
			if (!(in_burst && s_burst_indicator)) begin
				next_s_ptr = s_addr[`EPB_MEM_AW-1:0];
			end
			next_in_burst = s_burst_indicator;
			next_s_wait = s_rd && !s_wait;
			next_slv_drive = s_rd;
		end
		// Point past the word just moved, a read moves on its wait cycle
		if (slv_done && s_burst_indicator) begin
			next_s_ptr = slv_addr + {{(`EPB_MEM_AW-1){1'b0}}, 1'b1};
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_ptr <= '0;
			in_burst <= 1'b0;
			s_wait <= 1'b0;
			slv_drive <= 1'b0;
		end else begin
			s_ptr <= next_s_ptr;
			in_burst <= next_in_burst;
			s_wait <= next_s_wait;
			slv_drive <= next_slv_drive;
		end
	end
	// Data pins carry write data as master, memory words on slave reads
	assign o_data_oe = (own && m_wdrv) || slv_drive;
	assign o_data = slv_drive ? slv_rdata : m_data;
	// Open drain: pull low only while inserting a wait
	assign o_wait_release = 1'b0;
	assign o_wait_release_oe = s_wait;
	assign o_slave_wait = s_wait;

	// Internal memory, per-half write strobes
	epb_mem u_mem (
		.i_sys_clk (i_sys_clk),
		.i_we_low  (slv_act && s_wl),
		.i_we_high (slv_act && s_wh),
		.i_addr    (slv_addr),
		.i_wdata   (s_data),
		.o_rdata   (slv_rdata)
	);

	// ****************************************
	// Checks
	// ****************************************
	a_oe_follow_master: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		o_addr_oe == $past(i_is_master)) else $error("Address enable not tied to ownership");
	a_bank_decode: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!o_bank_select_0_n |-> o_addr[31:27] == 5'h06) else $error("Bank 0 decode wrong");
	a_host_decode: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!o_host_space_select_n |-> o_addr[31]) else $error("Host select decode wrong");
	a_wait_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state == epb_pkg::EPB_ACCESS && !s_ack && i_is_master |=> state == epb_pkg::EPB_ACCESS)
		else $error("Access ended during wait");
	a_ack_latency: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state == epb_pkg::EPB_ACCESS && acc_age != `EPB_ACK_LAT && i_is_master |=> state == epb_pkg::EPB_ACCESS)
		else $error("Access ended on a stale wait release");
	a_strobe_addr: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!o_read_strobe_n && $past(!o_read_strobe_n) |-> $stable(o_addr))
		else $error("Address moved under read strobe");
	a_wr_split: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!o_write_high_strobe_n && !o_write_low_strobe_n |-> !o_addr[0] || o_write_low_strobe_n)
		else $error("Write strobe split wrong");
	a_slave_wait: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		s_wait |=> !s_wait) else $error("Wait longer than one cycle");
	a_no_drive_slave: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!own |-> !o_strobe_oe && !o_select_oe) else $error("Slave drives controls");
	c_read: cover property (@(posedge i_sys_clk) !o_read_strobe_n ##1 o_req_done);
	c_wait: cover property (@(posedge i_sys_clk) state == epb_pkg::EPB_ACCESS && !s_ack);
	c_burst: cover property (@(posedge i_sys_clk) slv_act && in_burst);
endmodule : epb_ctrl
`default_nettype wire

// ===== tb/epb_slave_model.sv
`default_nettype none
`include "epb_cfg.svh"
// ********************************
// Far-side slave
// ********************************
module epb_slave_model (
	input  wire logic               i_sys_clk,
	input  wire logic               i_resetn,
	input  wire logic [3:0]         i_wait_cycles,   // Wait states per access
	input  wire logic [`EPB_AW-1:0] i_addr,          // Address wire
	input  wire logic               i_read_strobe_n,
	input  wire logic               i_write_low_strobe_n,
	input  wire logic               i_write_high_strobe_n,
	output logic                    o_wait_pull,     // Pulls wait release low
	output logic      [`EPB_DW-1:0] o_data           // Data onto the bus
);
	timeunit 1ns;
	timeprecision 1ns;
	logic               active; // Some strobe asserted
	logic [3:0]         count;  // Cycles into the access
	logic [`EPB_DW-1:0] last;   // Value last put on the bus
	assign active = !(i_read_strobe_n && i_write_low_strobe_n && i_write_high_strobe_n);
	// Stretch each access by the set count
	assign o_wait_pull = active && (count < i_wait_cycles);
	// Data tied to address; released bus shows the inverse
	assign o_data = i_read_strobe_n ? ~last : {~i_addr, i_addr};
	// Count access cycles, keep last bus value
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			count <= 4'h0;
			last  <= '0;
		end else begin
			count <= active ? count + {3'h0, count != 4'hf} : 4'h0;
			last  <= o_data;
		end
	end
endmodule : epb_slave_model
`default_nettype wire

// ===== tb/epb_ctrl_test.sv
`default_nettype none
`include "epb_cfg.svh"
module epb_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	// ********************************
	// Signals
	// ********************************
	logic               i_sys_clk = 1'b0; // 10 MHz clock
	logic               i_resetn;         // Active-low reset
	logic               i_is_master;      // Bus ownership
	epb_pkg::epb_req_t  i_req;            // Core request
	logic               o_req_done, o_eprom_boot_strap, o_slave_wait, o_addr_oe, o_data_oe;
	logic               o_read_strobe_n, o_write_low_strobe_n, o_write_high_strobe_n, o_strobe_oe;
	logic               o_wait_release, o_wait_release_oe, o_boot_memory_select_n, o_bank_select_0_n;
	logic               o_bank_select_1_n, o_host_space_select_n, o_select_oe, o_burst_indicator_n, o_burst_oe;
	logic [`EPB_DW-1:0] o_rd_data, o_data, p_data, tb_data; // Dut, far side, bench data
	logic [`EPB_AW-1:0] o_addr, tb_addr;                    // Dut and bench address
	logic               tb_rd_n, tb_wl_n, tb_wh_n, tb_boot_n, tb_bst_n; // Bench pin drive
	logic               pull, saw_wait;   // Far-side pull, slave wait seen
	logic [3:0]         waits;            // Far-side wait states
	int                 fails, total_checks;
	// Wire levels from all drivers
	wire logic [`EPB_AW-1:0] i_addr = o_addr_oe ? o_addr : tb_addr;
	wire logic [`EPB_DW-1:0] i_data = o_data_oe ? o_data : (i_is_master ? p_data : tb_data);
	wire logic i_read_strobe_n        = o_strobe_oe ? o_read_strobe_n : tb_rd_n;
	wire logic i_write_low_strobe_n   = o_strobe_oe ? o_write_low_strobe_n : tb_wl_n;
	wire logic i_write_high_strobe_n  = o_strobe_oe ? o_write_high_strobe_n : tb_wh_n;
	wire logic i_boot_memory_select_n = o_select_oe ? o_boot_memory_select_n : tb_boot_n;
	wire logic i_burst_indicator_n    = o_burst_oe ? o_burst_indicator_n : tb_bst_n;
	wire logic i_wait_release         = !(pull || (o_wait_release_oe && !o_wait_release));
	epb_ctrl u_dut (.i_sys_clk, .i_resetn, .i_is_master, .i_req, .o_req_done, .o_rd_data, .o_eprom_boot_strap,
		.o_slave_wait, .i_addr, .o_addr, .o_addr_oe, .i_data, .o_data, .o_data_oe, .i_read_strobe_n,
		.i_write_low_strobe_n, .i_write_high_strobe_n, .o_read_strobe_n, .o_write_low_strobe_n,
		.o_write_high_strobe_n, .o_strobe_oe, .i_wait_release, .o_wait_release, .o_wait_release_oe,
		.i_boot_memory_select_n, .o_boot_memory_select_n, .o_bank_select_0_n, .o_bank_select_1_n,
		.o_host_space_select_n, .o_select_oe, .i_burst_indicator_n, .o_burst_indicator_n, .o_burst_oe);
	epb_slave_model u_far (.i_sys_clk, .i_resetn, .i_wait_cycles(waits), .i_addr,
		.i_read_strobe_n(o_read_strobe_n | !o_strobe_oe),
		.i_write_low_strobe_n(o_write_low_strobe_n | !o_strobe_oe),
		.i_write_high_strobe_n(o_write_high_strobe_n | !o_strobe_oe), .o_wait_pull(pull), .o_data(p_data));
	// Clock
	always #50 i_sys_clk = ~i_sys_clk;
	// Note a slave wait state
	always @(negedge i_sys_clk) if (o_wait_release_oe === 1'b1 && i_wait_release === 1'b0) saw_wait <= 1'b1;
	// ********************************
	// Shared tasks
	// ********************************
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("Checks made %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test
	// Core access; f is {rd,wr,long,bus32,sdram,boot,burst}, stb the expected strobes
	task automatic master_op(input logic [6:0] f, input logic [`EPB_AW-1:0] a, input logic [2:0] stb);
		int         n;
		logic [3:0] sel;
		sel = ~{a[31:27] == 5'h06, a[31:27] == 5'h07, a[31], f[1]};
		@(negedge i_sys_clk);
		i_req = {f, a, a, ~a};
		for (n = 0; n < 40 && o_addr !== a; n++) @(negedge i_sys_clk);
		check(o_addr, a);
		check({o_read_strobe_n, o_write_low_strobe_n, o_write_high_strobe_n}, stb);
		check({o_bank_select_0_n, o_bank_select_1_n, o_host_space_select_n, o_boot_memory_select_n}, sel);
		check({o_burst_indicator_n, o_data_oe}, {~f[0], f[5]});
		if (f[5]) check(o_data, {a, ~a});
		repeat (waits) @(negedge i_sys_clk);
		check({o_read_strobe_n, o_write_low_strobe_n, o_write_high_strobe_n}, stb);
		for (n = 0; n < 40 && o_req_done !== 1'b1; n++) @(negedge i_sys_clk);
		check(o_req_done, 1'b1);
		i_req.rd = 1'b0;
		i_req.wr = 1'b0;
		@(negedge i_sys_clk);
		check({o_read_strobe_n, o_write_low_strobe_n, o_write_high_strobe_n}, 3'h7);
		if (f[6] && !f[2]) check(o_rd_data, {~a, a});
	endtask : master_op
	// Outside master access; stb drives {read, low, high}
	// A write strobe stands one cycle, a read two: the access and its one wait state
	task automatic slave_xfer(input logic [2:0] stb, input logic [63:0] d, output logic [63:0] q);
		@(negedge i_sys_clk);
		{tb_rd_n, tb_wl_n, tb_wh_n} = stb;
		tb_data = d;
		@(negedge i_sys_clk);
		if (!stb[2]) @(negedge i_sys_clk);
		{tb_rd_n, tb_wl_n, tb_wh_n} = 3'h7;
		tb_data = ~d;
		repeat (2) @(negedge i_sys_clk);
		q = i_data;
		repeat (3) @(negedge i_sys_clk);
	endtask : slave_xfer
	// ********************************
	// Scenarios
	// ********************************
	task automatic test_strap(input logic lvl);
		@(negedge i_sys_clk);
		i_resetn = 1'b0;
		tb_boot_n = lvl;
		repeat (16) @(negedge i_sys_clk);
		i_resetn = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		tb_boot_n = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		check(o_eprom_boot_strap, !lvl);
	endtask : test_strap
	task automatic test_master();
		i_is_master = 1'b1;
		waits = 4'h3;
		master_op(7'h20, 32'h3000_0002, 3'h5);
		master_op(7'h20, 32'h3800_0003, 3'h6);
		master_op(7'h31, 32'h8000_0004, 3'h4);
		master_op(7'h28, 32'h0000_0005, 3'h5);
		waits = 4'h0;
		master_op(7'h42, 32'h0000_0010, 3'h3);
		master_op(7'h44, 32'h0000_0021, 3'h7);
	endtask : test_master
	task automatic test_refused();
		@(negedge i_sys_clk);
		i_is_master = 1'b0;
		i_req = {7'h20, 32'h3000_0008, 64'h0};
		repeat (12) begin
			@(negedge i_sys_clk);
			check({o_req_done, o_addr_oe, o_data_oe, o_strobe_oe, o_select_oe, o_burst_oe}, 6'h00);
		end
		i_req.wr = 1'b0;
	endtask : test_refused
	task automatic test_slave();
		logic [63:0] q0, q1, qx;
		tb_addr = 32'h0000_0004;
		tb_bst_n = 1'b0;
		saw_wait = 1'b0;
		slave_xfer(3'h4, 64'h1111_2222_3333_4444, qx);
		tb_addr = 32'h0000_000c; // Burst target ignores this address
		slave_xfer(3'h4, 64'h5555_6666_7777_8888, qx);
		tb_bst_n = 1'b1;
		tb_addr = 32'h0000_0004;
		slave_xfer(3'h5, 64'h9999_aaaa_bbbb_cccc, qx);
		tb_bst_n = 1'b0;
		slave_xfer(3'h3, 64'h0, q0);
		tb_addr = 32'h0000_000c; // Burst target ignores this address
		slave_xfer(3'h3, 64'h0, q1);
		tb_bst_n = 1'b1;
		check(q0, 64'h1111_2222_bbbb_cccc);
		check(q1, 64'h5555_6666_7777_8888);
		check(saw_wait, 1'b1);
	endtask : test_slave
	// ********************************
	// Main sequence and watchdog
	// ********************************
	initial begin
		i_resetn = 1'b0;
		i_is_master = 1'b0;
		i_req = '0;
		tb_addr = '0;
		tb_data = '0;
		{tb_rd_n, tb_wl_n, tb_wh_n, tb_bst_n} = 4'hf;
		tb_boot_n = 1'b0;
		waits = 4'h0;
		saw_wait = 1'b0;
		fails = 0;
		total_checks = 0;
		test_strap(1'b0);
		test_master();
		test_refused();
		test_slave();
		test_strap(1'b1);
		stop_test();
	end
	initial begin
		repeat (3000) @(posedge i_sys_clk);
		fails++;
		stop_test();
	end
endmodule : epb_ctrl_test
`default_nettype wire
